/* rtl/cid_defs.svh */
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH
// Function
// RL1: the fixed word 0x000b is recognised as a branch offset by the accumulator and takes two cycles.
// RL2: the fixed word 0x000a is recognised as a call whose target comes from the accumulator and takes two cycles.
// RL3: prefix 11 0100 with an 8-bit literal returns from a subroutine, loads the literal and takes two cycles.
// RL4: word 0x0062 copies the accumulator into the timer configuration register in one cycle.
// RL5: word 0x0063 enters standby in one cycle and updates the timeout and power-down flags.
// RL6: words 0x0060 to 0x0067 (other fixed words excluded) load a pin-direction register chosen by f in one cycle.
// RL7: prefix 11 0001 0 adds the six-bit literal to the selected indirect pointer in one cycle.
// RL8: prefix 00 0000 0001 0 loads through the selected pointer with pre/post inc/dec and updates the zero flag.
// RL9: prefix 11 1111 0 loads from pointer plus offset in one cycle and updates the zero flag.
// RL10: group 00 0000 0001 1nmm stores through the selected pointer with its modifier and leaves the flags alone.
// RL11: prefix 11 1111 1 stores at pointer plus offset in one cycle.
// RL12: an instruction that changes the program counter or whose test is true takes two cycles, the second a no-op.
// RL13: an indirect move addressing an indirection register while the pointer msb is set takes one extra cycle.
// RL14: each 14-bit word is one instruction; fixed opcode bits are matched first, then operand fields extracted.

// fixed words
`define CID_W_NOP      14'h0000
`define CID_W_RESET    14'h0001
`define CID_W_RETURN   14'h0008
`define CID_W_RETFIE   14'h0009
`define CID_W_CALLACC  14'h000a
`define CID_W_BRACC    14'h000b
`define CID_W_OPTION   14'h0062
`define CID_W_SLEEP    14'h0063
`define CID_W_CLRWDT   14'h0064
`define CID_M_FULL     14'h3fff
// masked groups: mask then match value
`define CID_M_PINDIR   14'h3ff8
`define CID_V_PINDIR   14'h0060
`define CID_M_BRA      14'h3e00
`define CID_V_BRA      14'h3200
`define CID_M_JUMP     14'h3800
`define CID_V_CALL     14'h2000
`define CID_V_GOTO     14'h2800
`define CID_M_RETLIT   14'h3f00
`define CID_V_RETLIT   14'h3400
`define CID_M_ADDPTR   14'h3f80
`define CID_V_ADDPTR   14'h3100
`define CID_M_INDMM    14'h3ff8
`define CID_V_LDMM     14'h0010
`define CID_V_STMM     14'h0018
`define CID_M_INDOFS   14'h3f80
`define CID_V_LDOFS    14'h3f00
`define CID_V_STOFS    14'h3f80
// operand field positions
`define CID_F_PTR_OFS  6
`define CID_F_PTR_MM   2
`define CID_F_MM_PRE   1
`define CID_F_MM_DEC   0
// reset values of the status flags
`define CID_RST_TIMEOUT 1'b1
`define CID_RST_PWRDN   1'b1
`endif

/* rtl/cid_pkg.sv */
package cid_pkg;
    // decoded operation
    typedef enum logic [4:0] {
        CID_OP_NOP     = 5'h00,
        CID_OP_RESET   = 5'h01,
        CID_OP_RETURN  = 5'h02,
        CID_OP_RETFIE  = 5'h03,
        CID_OP_CALLACC = 5'h04,
        CID_OP_BRACC   = 5'h05,
        CID_OP_OPTION  = 5'h06,
        CID_OP_SLEEP   = 5'h07,
        CID_OP_CLRWDT  = 5'h08,
        CID_OP_PINDIR  = 5'h09,
        CID_OP_BRA     = 5'h0a,
        CID_OP_CALL    = 5'h0b,
        CID_OP_GOTO    = 5'h0c,
        CID_OP_RETLIT  = 5'h0d,
        CID_OP_ADDPTR  = 5'h0e,
        CID_OP_LDMM    = 5'h0f,
        CID_OP_STMM    = 5'h10,
        CID_OP_LDOFS   = 5'h11,
        CID_OP_STOFS   = 5'h12,
        CID_OP_OTHER   = 5'h13
    } cid_op_t;
    // cycle sequencer states
    typedef enum logic [1:0] {
        CID_ST_READY = 2'b00,
        CID_ST_NOP   = 2'b01,
        CID_ST_EXTRA = 2'b10
    } cid_state_t;
endpackage : cid_pkg

/* rtl/cid_dec_if.sv */
`timescale 1ns/1ps
interface cid_dec_if;
    cid_pkg::cid_op_t op;
    logic [10:0] operand;
    logic ptr_sel;
    logic ptr_pre;
    logic ptr_dec;
    logic [2:0] pin_sel;
    logic pc_change;
    logic indirect;
    logic acc_load;
    logic zero_update;
    modport dec (output op, operand, ptr_sel, ptr_pre, ptr_dec, pin_sel, pc_change, indirect, acc_load, zero_update);
    modport sink (input op, operand, ptr_sel, ptr_pre, ptr_dec, pin_sel, pc_change, indirect, acc_load, zero_update);
endinterface : cid_dec_if

/* rtl/cid_field_dec.sv */
`timescale 1ns/1ps
`include "cid_defs.svh"
module cid_field_dec (
    // fetched word
    input wire logic [13:0] word,
    // decoded fields
    cid_dec_if.dec d
);
    // masked compare of the word against an opcode pattern
    function automatic logic cid_match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
        cid_match = ((w & m) == v);
    endfunction : cid_match

    // fixed words first, then masked groups, then fields
    always_comb begin
        d.op = cid_pkg::CID_OP_OTHER; // [RL14]
        d.operand = 11'h000;
        d.ptr_sel = 1'b0;
        d.ptr_pre = 1'b0;
        d.ptr_dec = 1'b0;
        d.pin_sel = word[2:0];
        d.pc_change = 1'b0;
        d.indirect = 1'b0;
        d.acc_load = 1'b0;
        d.zero_update = 1'b0;
        if (cid_match(word, `CID_M_FULL, `CID_W_NOP)) begin
            d.op = cid_pkg::CID_OP_NOP;
        end else if (cid_match(word, `CID_M_FULL, `CID_W_RESET)) begin
            d.op = cid_pkg::CID_OP_RESET;
        end else if (cid_match(word, `CID_M_FULL, `CID_W_RETURN)) begin
            d.op = cid_pkg::CID_OP_RETURN;
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_FULL, `CID_W_RETFIE)) begin
            d.op = cid_pkg::CID_OP_RETFIE;
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_FULL, `CID_W_CALLACC)) begin
            d.op = cid_pkg::CID_OP_CALLACC; // [RL2]
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_FULL, `CID_W_BRACC)) begin
            d.op = cid_pkg::CID_OP_BRACC; // [RL1]
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_FULL, `CID_W_OPTION)) begin
            d.op = cid_pkg::CID_OP_OPTION; // [RL4]
        end else if (cid_match(word, `CID_M_FULL, `CID_W_SLEEP)) begin
            d.op = cid_pkg::CID_OP_SLEEP; // [RL5]
        end else if (cid_match(word, `CID_M_FULL, `CID_W_CLRWDT)) begin
            d.op = cid_pkg::CID_OP_CLRWDT;
        end else if (cid_match(word, `CID_M_PINDIR, `CID_V_PINDIR)) begin
            d.op = cid_pkg::CID_OP_PINDIR; // [RL6]
        end else if (cid_match(word, `CID_M_BRA, `CID_V_BRA)) begin
            d.op = cid_pkg::CID_OP_BRA;
            d.operand = {2'h0, word[8:0]};
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_JUMP, `CID_V_CALL)) begin
            d.op = cid_pkg::CID_OP_CALL;
            d.operand = word[10:0];
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_JUMP, `CID_V_GOTO)) begin
            d.op = cid_pkg::CID_OP_GOTO;
            d.operand = word[10:0];
            d.pc_change = 1'b1;
        end else if (cid_match(word, `CID_M_RETLIT, `CID_V_RETLIT)) begin
            d.op = cid_pkg::CID_OP_RETLIT; // [RL3]
            d.operand = {3'h0, word[7:0]};
            d.pc_change = 1'b1;
            d.acc_load = 1'b1;
        end else if (cid_match(word, `CID_M_ADDPTR, `CID_V_ADDPTR)) begin
            d.op = cid_pkg::CID_OP_ADDPTR; // [RL7]
            d.operand = {5'h00, word[5:0]};
            d.ptr_sel = word[`CID_F_PTR_OFS];
        end else if (cid_match(word, `CID_M_INDMM, `CID_V_LDMM) || cid_match(word, `CID_M_INDMM, `CID_V_STMM)) begin
            d.op = word[3] ? cid_pkg::CID_OP_STMM : cid_pkg::CID_OP_LDMM; // [RL8] [RL10]
            d.ptr_sel = word[`CID_F_PTR_MM];
            d.ptr_pre = ~word[`CID_F_MM_PRE];
            d.ptr_dec = word[`CID_F_MM_DEC];
            d.indirect = 1'b1;
            d.acc_load = ~word[3];
            d.zero_update = ~word[3];
        end else if (cid_match(word, `CID_M_INDOFS, `CID_V_LDOFS) || cid_match(word, `CID_M_INDOFS, `CID_V_STOFS)) begin
            d.op = word[7] ? cid_pkg::CID_OP_STOFS : cid_pkg::CID_OP_LDOFS; // [RL9] [RL11]
            d.operand = {5'h00, word[5:0]};
            d.ptr_sel = word[`CID_F_PTR_OFS];
            d.indirect = 1'b1;
            d.acc_load = ~word[7];
            d.zero_update = ~word[7];
        end
    end
endmodule : cid_field_dec

/* rtl/cid_instr_decode.sv */
`timescale 1ns/1ps
`include "cid_defs.svh"
module cid_instr_decode (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // instruction fetch
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic cond_true,
    // pointer state from the core
    input wire logic [1:0] ptr_msb,
    input wire logic target_is_indirection,
    // sequencing
    output logic instr_ready,
    output logic nop_cycle,
    // decoded operation and fields
    output cid_pkg::cid_op_t op_code,
    output logic [10:0] operand,
    output logic ptr_sel,
    output logic ptr_pre,
    output logic ptr_dec,
    output logic [2:0] pin_dir_sel,
    // execute strobes
    output logic pc_load,
    output logic acc_load,
    output logic zero_update,
    output logic timer_cfg_write,
    output logic pin_dir_write,
    output logic pointer_add,
    output logic indirect_load,
    output logic indirect_store,
    output logic standby_enter,
    output logic wdt_clear,
    output logic soft_reset,
    // status flags
    output logic timeout_flag,
    output logic power_down_flag
);
    ////////////////////////////////////////////////////////////////////////////////
    cid_dec_if dif ();

    // field decoder for the word on the fetch port
    cid_field_dec u_dec (
        .word(instr_word),
        .d(dif.dec)
    );

    ////////////////////////////////////////////////////////////////////////////////
    cid_pkg::cid_state_t state_reg, state_next;
    logic ready_reg, ready_next;
    logic nop_reg, nop_next;
    cid_pkg::cid_op_t op_reg, op_next;
    logic [10:0] operand_reg, operand_next;
    logic ptr_sel_reg, ptr_sel_next;
    logic ptr_pre_reg, ptr_pre_next;
    logic ptr_dec_reg, ptr_dec_next;
    logic [2:0] pin_sel_reg, pin_sel_next;
    logic pc_load_reg, pc_load_next;
    logic acc_load_reg, acc_load_next;
    logic zero_upd_reg, zero_upd_next;
    logic tmr_wr_reg, tmr_wr_next;
    logic pin_wr_reg, pin_wr_next;
    logic ptr_add_reg, ptr_add_next;
    logic ind_ld_reg, ind_ld_next;
    logic ind_st_reg, ind_st_next;
    logic standby_reg, standby_next;
    logic wdt_clr_reg, wdt_clr_next;
    logic sreset_reg, sreset_next;
    logic timeout_reg, timeout_next;
    logic pwrdn_reg, pwrdn_next;
    logic accept;
    logic extra_cycle;
    logic two_cycle;

    // a word is taken only while the sequencer is ready
    assign accept = instr_valid && ready_reg;
    // indirection register behind a pointer with its msb set costs a cycle
    assign extra_cycle = dif.indirect && target_is_indirection && ptr_msb[dif.ptr_sel]; // [RL13]
    // program counter change or true test forces a trailing no-op
    assign two_cycle = dif.pc_change || cond_true; // [RL12]

    ////////////////////////////////////////////////////////////////////////////////
    // next state of sequencer, fields, strobes and flags
    always_comb begin
        state_next = state_reg;
        ready_next = ready_reg;
        nop_next = 1'b0;
        op_next = cid_pkg::CID_OP_NOP;
        operand_next = operand_reg;
        ptr_sel_next = ptr_sel_reg;
        ptr_pre_next = ptr_pre_reg;
        ptr_dec_next = ptr_dec_reg;
        pin_sel_next = pin_sel_reg;
        pc_load_next = 1'b0;
        acc_load_next = 1'b0;
        zero_upd_next = 1'b0;
        tmr_wr_next = 1'b0;
        pin_wr_next = 1'b0;
        ptr_add_next = 1'b0;
        ind_ld_next = 1'b0;
        ind_st_next = 1'b0;
        standby_next = 1'b0;
        wdt_clr_next = 1'b0;
        sreset_next = 1'b0;
        timeout_next = timeout_reg;
        pwrdn_next = pwrdn_reg;
        unique case (state_reg)
            cid_pkg::CID_ST_READY: begin
                if (accept) begin
                    op_next = dif.op;
                    operand_next = dif.operand;
                    ptr_sel_next = dif.ptr_sel;
                    ptr_pre_next = dif.ptr_pre;
                    ptr_dec_next = dif.ptr_dec;
                    pin_sel_next = dif.pin_sel;
                    pc_load_next = dif.pc_change; // [RL1] [RL2] [RL3]
                    acc_load_next = dif.acc_load;
                    zero_upd_next = dif.zero_update; // [RL8] [RL9]
                    tmr_wr_next = (dif.op == cid_pkg::CID_OP_OPTION); // [RL4]
                    pin_wr_next = (dif.op == cid_pkg::CID_OP_PINDIR); // [RL6]
                    ptr_add_next = (dif.op == cid_pkg::CID_OP_ADDPTR); // [RL7]
                    ind_ld_next = (dif.op == cid_pkg::CID_OP_LDMM) || (dif.op == cid_pkg::CID_OP_LDOFS);
                    ind_st_next = (dif.op == cid_pkg::CID_OP_STMM) || (dif.op == cid_pkg::CID_OP_STOFS); // [RL10] [RL11]
                    standby_next = (dif.op == cid_pkg::CID_OP_SLEEP); // [RL5]
                    wdt_clr_next = (dif.op == cid_pkg::CID_OP_CLRWDT);
                    sreset_next = (dif.op == cid_pkg::CID_OP_RESET);
                    // standby sets time-out, clears power-down; watchdog clear sets both
                    if (dif.op == cid_pkg::CID_OP_SLEEP) begin
                        timeout_next = 1'b1; // [RL5]
                        pwrdn_next = 1'b0;
                    end else if (dif.op == cid_pkg::CID_OP_CLRWDT) begin
                        timeout_next = 1'b1;
                        pwrdn_next = 1'b1;
                    end
                    if (two_cycle) begin
                        state_next = cid_pkg::CID_ST_NOP; // [RL12]
                        ready_next = 1'b0;
                    end else if (extra_cycle) begin
                        state_next = cid_pkg::CID_ST_EXTRA; // [RL13]
                        ready_next = 1'b0;
                    end
                end
            end
            cid_pkg::CID_ST_NOP, cid_pkg::CID_ST_EXTRA: begin
                // stall cycle executes as a no-op
                nop_next = 1'b1;
                state_next = cid_pkg::CID_ST_READY;
                ready_next = 1'b1;
            end
            default: begin
                state_next = cid_pkg::CID_ST_READY;
                ready_next = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register every next value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= cid_pkg::CID_ST_READY;
            ready_reg <= 1'b1;
            nop_reg <= 1'b0;
            op_reg <= cid_pkg::CID_OP_NOP;
            operand_reg <= 11'h000;
            ptr_sel_reg <= 1'b0;
            ptr_pre_reg <= 1'b0;
            ptr_dec_reg <= 1'b0;
            pin_sel_reg <= 3'h0;
            pc_load_reg <= 1'b0;
            acc_load_reg <= 1'b0;
            zero_upd_reg <= 1'b0;
            tmr_wr_reg <= 1'b0;
            pin_wr_reg <= 1'b0;
            ptr_add_reg <= 1'b0;
            ind_ld_reg <= 1'b0;
            ind_st_reg <= 1'b0;
            standby_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
            sreset_reg <= 1'b0;
            timeout_reg <= `CID_RST_TIMEOUT;
            pwrdn_reg <= `CID_RST_PWRDN;
        end else begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            nop_reg <= nop_next;
            op_reg <= op_next;
            operand_reg <= operand_next;
            ptr_sel_reg <= ptr_sel_next;
            ptr_pre_reg <= ptr_pre_next;
            ptr_dec_reg <= ptr_dec_next;
            pin_sel_reg <= pin_sel_next;
            pc_load_reg <= pc_load_next;
            acc_load_reg <= acc_load_next;
            zero_upd_reg <= zero_upd_next;
            tmr_wr_reg <= tmr_wr_next;
            pin_wr_reg <= pin_wr_next;
            ptr_add_reg <= ptr_add_next;
            ind_ld_reg <= ind_ld_next;
            ind_st_reg <= ind_st_next;
            standby_reg <= standby_next;
            wdt_clr_reg <= wdt_clr_next;
            sreset_reg <= sreset_next;
            timeout_reg <= timeout_next;
            pwrdn_reg <= pwrdn_next;
        end
    end

    // outputs straight from flops
    assign instr_ready = ready_reg;
    assign nop_cycle = nop_reg;
    assign op_code = op_reg;
    assign operand = operand_reg;
    assign ptr_sel = ptr_sel_reg;
    assign ptr_pre = ptr_pre_reg;
    assign ptr_dec = ptr_dec_reg;
    assign pin_dir_sel = pin_sel_reg;
    assign pc_load = pc_load_reg;
    assign acc_load = acc_load_reg;
    assign zero_update = zero_upd_reg;
    assign timer_cfg_write = tmr_wr_reg;
    assign pin_dir_write = pin_wr_reg;
    assign pointer_add = ptr_add_reg;
    assign indirect_load = ind_ld_reg;
    assign indirect_store = ind_st_reg;
    assign standby_enter = standby_reg;
    assign wdt_clear = wdt_clr_reg;
    assign soft_reset = sreset_reg;
    assign timeout_flag = timeout_reg;
    assign power_down_flag = pwrdn_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the sequenced outputs
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // issue cycle, then stall no-op, then ready again
    sequence s_stall_tail;
        (!instr_ready && !nop_cycle) ##1 (instr_ready && nop_cycle && op_code == cid_pkg::CID_OP_NOP);
    endsequence
    sequence s_single;
        instr_ready && !nop_cycle;
    endsequence

    a_bracc_two_cycle: assert property (accept && instr_word == `CID_W_BRACC
        |=> (op_code == cid_pkg::CID_OP_BRACC && pc_load) ##0 s_stall_tail) // [RL1]
        else $error("branch by accumulator not two cycles");
    a_callacc_two_cycle: assert property (accept && instr_word == `CID_W_CALLACC
        |=> (op_code == cid_pkg::CID_OP_CALLACC && pc_load) ##0 s_stall_tail) // [RL2]
        else $error("call by accumulator not two cycles");
    a_return_literal: assert property (accept && (instr_word & `CID_M_RETLIT) == `CID_V_RETLIT
        |=> (acc_load && pc_load && operand[7:0] == $past(instr_word[7:0])) ##0 s_stall_tail) // [RL3]
        else $error("return with literal wrong");
    a_option_single: assert property (accept && !cond_true && instr_word == `CID_W_OPTION
        |=> timer_cfg_write and s_single) // [RL4]
        else $error("timer config write wrong");
    a_sleep_flags: assert property (accept && !cond_true && instr_word == `CID_W_SLEEP
        |=> standby_enter && timeout_flag && !power_down_flag and s_single) // [RL5]
        else $error("standby flags wrong");
    a_pindir_select: assert property (accept && !cond_true && dif.op == cid_pkg::CID_OP_PINDIR
        |=> pin_dir_write && pin_dir_sel == $past(instr_word[2:0]) and s_single) // [RL6]
        else $error("pin direction load wrong");
    a_addptr_fields: assert property (accept && (instr_word & `CID_M_ADDPTR) == `CID_V_ADDPTR
        |=> pointer_add && ptr_sel == $past(instr_word[6]) && operand[5:0] == $past(instr_word[5:0])) // [RL7]
        else $error("add to pointer wrong");
    a_ldmm_modifier: assert property (accept && (instr_word & `CID_M_INDMM) == `CID_V_LDMM
        |=> indirect_load && zero_update && ptr_pre == !$past(instr_word[1]) && ptr_dec == $past(instr_word[0])) // [RL8]
        else $error("indirect load modifier wrong");
    a_ldofs_zero: assert property (accept && (instr_word & `CID_M_INDOFS) == `CID_V_LDOFS
        |=> indirect_load && zero_update && operand[5:0] == $past(instr_word[5:0])) // [RL9]
        else $error("indexed load wrong");
    a_store_no_flags: assert property (accept && (instr_word & `CID_M_INDMM) == `CID_V_STMM
        |=> indirect_store && !zero_update && !acc_load) // [RL10]
        else $error("indirect store touched flags");
    a_stofs_fields: assert property (accept && (instr_word & `CID_M_INDOFS) == `CID_V_STOFS
        |=> indirect_store && ptr_sel == $past(instr_word[6]) && !zero_update) // [RL11]
        else $error("indexed store wrong");
    a_cond_nop: assert property (accept && cond_true |=> s_stall_tail) // [RL12]
        else $error("true test did not add a no-op");
    a_extra_cycle: assert property (accept && !two_cycle && extra_cycle |=> s_stall_tail) // [RL13]
        else $error("extra indirect cycle missing");
    a_no_extra: assert property (accept && !two_cycle && !extra_cycle |=> instr_ready) // [RL13]
        else $error("unexpected stall");
endmodule : cid_instr_decode

/* bench/cid_prog_mem.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////
// program memory model: presents words in order, holds each until taken
module cid_prog_mem (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // fetch handshake
    input wire logic instr_ready,
    output logic [13:0] instr_word,
    output logic instr_valid
);
    logic [13:0] prog [0:3];
    int len = 0;
    int idx = 0;
    logic took = 1'b0;
    initial instr_word = 14'h0000;
    initial instr_valid = 1'b0;
    // note the edge where a whole word was taken
    always @(posedge clock) begin
        took <= instr_valid & instr_ready & ~rst;
    end
    // next word after the falling edge; an idle bus toggles so stale data never looks valid
    always @(negedge clock) begin
        if (took)
            idx = idx + 1;
        if (idx < len) begin
            instr_valid <= 1'b1;
            instr_word <= prog[idx];
        end else begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
        end
    end
endmodule : cid_prog_mem

/* bench/test_cpu_control_instr_decode.sv */
`timescale 1ns/1ps
module test_cpu_control_instr_decode;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cond_true = 1'b0;
    logic [1:0] ptr_msb = 2'b00;
    logic target_is_indirection = 1'b0;
    logic [13:0] instr_word;
    logic instr_valid, instr_ready, nop_cycle, ptr_sel, ptr_pre, ptr_dec;
    logic pc_load, acc_load, zero_update, timer_cfg_write, pin_dir_write, pointer_add;
    logic indirect_load, indirect_store, standby_enter, wdt_clear, soft_reset;
    logic timeout_flag, power_down_flag;
    logic [10:0] operand;
    logic [2:0] pin_dir_sel;
    cid_pkg::cid_op_t op_code;
    int err_count = 0;
    int comparisons = 0;
    wire logic [10:0] strobes = {pc_load, acc_load, zero_update, timer_cfg_write, pin_dir_write, pointer_add,
        indirect_load, indirect_store, standby_enter, wdt_clear, soft_reset};
    // 50 ns clock
    always #25 clock = ~clock;
    cid_prog_mem pm (.clock(clock), .rst(rst), .instr_ready(instr_ready), .instr_word(instr_word),
        .instr_valid(instr_valid));
    cid_instr_decode dut (.clock(clock), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
        .cond_true(cond_true), .ptr_msb(ptr_msb), .target_is_indirection(target_is_indirection),
        .instr_ready(instr_ready), .nop_cycle(nop_cycle), .op_code(op_code), .operand(operand),
        .ptr_sel(ptr_sel), .ptr_pre(ptr_pre), .ptr_dec(ptr_dec), .pin_dir_sel(pin_dir_sel),
        .pc_load(pc_load), .acc_load(acc_load), .zero_update(zero_update), .timer_cfg_write(timer_cfg_write),
        .pin_dir_write(pin_dir_write), .pointer_add(pointer_add), .indirect_load(indirect_load),
        .indirect_store(indirect_store), .standby_enter(standby_enter), .wdt_clear(wdt_clear),
        .soft_reset(soft_reset), .timeout_flag(timeout_flag), .power_down_flag(power_down_flag));
    //////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_op(input cid_pkg::cid_op_t got, input cid_pkg::cid_op_t exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: operation %h expected %h", $time, got, exp);
        end
    endtask : chk_op
    task automatic load(input logic [13:0] w0, input logic [13:0] w1, input int n);
        #1;
        pm.prog[0] = w0;
        pm.prog[1] = w1;
        pm.len = n;
        pm.idx = 0;
    endtask : load
    // one word through the decoder, judged in its answer cycle and the cycle after
    task automatic exec1(input logic [13:0] w, input logic c, input logic [1:0] m, input logic t,
        input cid_pkg::cid_op_t op, input logic [10:0] strb, input logic [10:0] opnd, input logic [2:0] ps,
        input logic stall);
        cond_true <= c;
        ptr_msb <= m;
        target_is_indirection <= t;
        load(w, 14'h0000, 1);
        repeat (2) @(negedge clock);
        chk_op(op_code, op);
        chk(16'(strobes), 16'(strb));
        chk(16'(operand), 16'(opnd));
        chk(16'({ptr_sel, ptr_pre, ptr_dec}), 16'(ps));
        chk(16'(instr_ready), 16'(!stall));
        @(negedge clock);
        chk(16'(nop_cycle), 16'(stall));
        chk(16'({instr_ready, strobes}), 16'h0800);
        cond_true <= 1'b0;
    endtask : exec1
    //////////////////////////////////////////////////////////////
    task automatic sc_two_cycle();
        exec1(14'h000b, 0, 0, 0, cid_pkg::CID_OP_BRACC, 11'h400, 0, 0, 1);
        exec1(14'h000a, 0, 0, 0, cid_pkg::CID_OP_CALLACC, 11'h400, 0, 0, 1);
        exec1(14'h34a5, 0, 0, 0, cid_pkg::CID_OP_RETLIT, 11'h600, 11'h0a5, 0, 1);
        exec1(14'h0008, 0, 0, 0, cid_pkg::CID_OP_RETURN, 11'h400, 0, 0, 1);
        exec1(14'h0009, 0, 0, 0, cid_pkg::CID_OP_RETFIE, 11'h400, 0, 0, 1);
        exec1(14'h2abc, 0, 0, 0, cid_pkg::CID_OP_GOTO, 11'h400, 11'h2bc, 0, 1);
        exec1(14'h2123, 0, 0, 0, cid_pkg::CID_OP_CALL, 11'h400, 11'h123, 0, 1);
        exec1(14'h3345, 0, 0, 0, cid_pkg::CID_OP_BRA, 11'h400, 11'h145, 0, 1);
        exec1(14'h0062, 1, 0, 0, cid_pkg::CID_OP_OPTION, 11'h080, 0, 0, 1);
    endtask : sc_two_cycle
    task automatic sc_single();
        exec1(14'h0062, 0, 0, 0, cid_pkg::CID_OP_OPTION, 11'h080, 0, 0, 0);
        exec1(14'h0001, 0, 0, 0, cid_pkg::CID_OP_RESET, 11'h001, 0, 0, 0);
        exec1(14'h0065, 0, 0, 0, cid_pkg::CID_OP_PINDIR, 11'h040, 0, 0, 0);
        chk(16'(pin_dir_sel), 16'h0005);
        exec1(14'h316a, 0, 0, 0, cid_pkg::CID_OP_ADDPTR, 11'h020, 11'h02a, 3'b100, 0);
        exec1(14'h0063, 0, 0, 0, cid_pkg::CID_OP_SLEEP, 11'h004, 0, 0, 0);
        chk(16'({timeout_flag, power_down_flag}), 16'h0002);
        exec1(14'h0064, 0, 0, 0, cid_pkg::CID_OP_CLRWDT, 11'h002, 0, 0, 0);
        chk(16'({timeout_flag, power_down_flag}), 16'h0003);
    endtask : sc_single
    task automatic sc_indirect();
        exec1(14'h0015, 0, 2'b10, 1, cid_pkg::CID_OP_LDMM, 11'h310, 0, 3'b111, 1);
        exec1(14'h0015, 0, 2'b01, 1, cid_pkg::CID_OP_LDMM, 11'h310, 0, 3'b111, 0);
        exec1(14'h001a, 0, 2'b01, 1, cid_pkg::CID_OP_STMM, 11'h008, 0, 0, 1);
        exec1(14'h3f3f, 0, 2'b01, 0, cid_pkg::CID_OP_LDOFS, 11'h310, 11'h03f, 0, 0);
        exec1(14'h3fc1, 0, 2'b10, 1, cid_pkg::CID_OP_STOFS, 11'h008, 11'h001, 3'b100, 1);
    endtask : sc_indirect
    // a held word is ignored during the stall and taken right after it
    task automatic sc_back_to_back();
        load(14'h000b, 14'h0062, 2);
        repeat (2) @(negedge clock);
        chk(16'({instr_ready, pc_load}), 16'h0001);
        @(negedge clock);
        chk_op(op_code, cid_pkg::CID_OP_NOP);
        @(negedge clock);
        chk(16'(strobes), 16'h0080);
    endtask : sc_back_to_back
    task automatic give_verdict();
        $display("comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst <= 1'b0;
        chk(16'({instr_ready, strobes, timeout_flag, power_down_flag}), 16'h2003);
        chk_op(op_code, cid_pkg::CID_OP_NOP);
        sc_two_cycle();
        sc_single();
        sc_indirect();
        sc_back_to_back();
        give_verdict();
    end
    // watchdog against a hung handshake
    initial begin
        #(2000 * 50);
        err_count++;
        give_verdict();
    end
endmodule : test_cpu_control_instr_decode
